/* core/ptb_pkg.sv */
package ptb_pkg;

	localparam int CNT_W  = 15;
	localparam int PRE_W  = 6;
	localparam int POST_W = 4;

	typedef enum logic [1:0] {
		MODE_FREE      = 2'b00,
		MODE_SINGLE    = 2'b01,
		MODE_UPDOWN    = 2'b10,
		MODE_UPDOWN_DU = 2'b11
	} ptb_mode_e;

	typedef logic [CNT_W-1:0] ptb_count_t;

	// Prescaler select codes 0..3 give 1:1, 1:4, 1:16, 1:64
	localparam logic [PRE_W-1:0] PRE_MASK_1  = 6'h00;
	localparam logic [PRE_W-1:0] PRE_MASK_4  = 6'h03;
	localparam logic [PRE_W-1:0] PRE_MASK_16 = 6'h0F;
	localparam logic [PRE_W-1:0] PRE_MASK_64 = 6'h3F;

	localparam ptb_count_t         COUNT_RESET  = 15'h0000;
	localparam ptb_count_t         PERIOD_RESET = 15'h0000;
	localparam ptb_count_t         COUNT_ZERO   = 15'h0000;
	localparam ptb_count_t         COUNT_ONE    = 15'h0001;
	localparam ptb_mode_e          MODE_RESET   = MODE_FREE;
	localparam logic [1:0]         PRESEL_RESET = 2'h0;
	localparam logic [POST_W-1:0]  POSTSEL_RESET = 4'h0;
	localparam logic [PRE_W-1:0]   PRE_CNT_RESET = 6'h00;
	localparam logic [POST_W-1:0]  POST_CNT_RESET = 4'h0;

endpackage : ptb_pkg

/* core/ptb_scale_if.sv */
interface ptb_scale_if;
	import ptb_pkg::*;

	logic                clr;
	logic [1:0]          pre_sel;
	logic                tick;
	logic [POST_W-1:0]   post_sel;
	logic                evt_in;
	logic                evt_out;

	modport core (output clr, output pre_sel, input tick, output post_sel, output evt_in, input evt_out);
	modport pre  (input clr, input pre_sel, output tick);
	modport post (input clr, input post_sel, input evt_in, output evt_out);

endinterface : ptb_scale_if

/* core/ptb_prescaler.sv */
module ptb_prescaler
	import ptb_pkg::*;
(
	input  wire logic   clk_in,
	input  wire logic   reset_in,
	ptb_scale_if.pre    sc
);

	logic [PRE_W-1:0] cnt_r;
	logic [PRE_W-1:0] cnt_nxt;
	logic [PRE_W-1:0] mask;

	always_comb begin
		case (sc.pre_sel)
			2'h0:    mask = PRE_MASK_1;
			2'h1:    mask = PRE_MASK_4;
			2'h2:    mask = PRE_MASK_16;
			default: mask = PRE_MASK_64;
		endcase
		sc.tick = ((cnt_r & mask) == mask);
		if (sc.clr) begin
			cnt_nxt = PRE_CNT_RESET;
		end else if (sc.tick) begin
			cnt_nxt = PRE_CNT_RESET;
		end else begin
			cnt_nxt = cnt_r + 6'h01;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cnt_r <= PRE_CNT_RESET;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule // ptb_prescaler

/* core/ptb_postscaler.sv */
module ptb_postscaler
	import ptb_pkg::*;
(
	input  wire logic   clk_in,
	input  wire logic   reset_in,
	ptb_scale_if.post   sc
);

	logic [POST_W-1:0] cnt_r;
	logic [POST_W-1:0] cnt_nxt;

	always_comb begin
		sc.evt_out = sc.evt_in && (cnt_r == sc.post_sel);
		if (sc.clr) begin
			cnt_nxt = POST_CNT_RESET;
		end else if (sc.evt_out) begin
			cnt_nxt = POST_CNT_RESET;
		end else if (sc.evt_in) begin
			cnt_nxt = cnt_r + 4'h1;
		end else begin
			cnt_nxt = cnt_r;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cnt_r <= POST_CNT_RESET;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule // ptb_postscaler

/* core/ptb_timebase.sv */
module ptb_timebase
	import ptb_pkg::*;
(
	input  wire logic              CLK_IN,
	input  wire logic              RESET_IN,
	input  wire logic              CTRL_WR_IN,
	input  wire logic              CTRL_ENABLE_IN,
	input  wire ptb_pkg::ptb_mode_e CTRL_MODE_IN,
	input  wire logic [1:0]        CTRL_PRESCALER_IN,
	input  wire logic [3:0]        CTRL_POSTSCALER_IN,
	input  wire logic              COUNT_WR_IN,
	input  wire ptb_pkg::ptb_count_t COUNT_WDATA_IN,
	input  wire logic              PERIOD_WR_IN,
	input  wire ptb_pkg::ptb_count_t PERIOD_WDATA_IN,
	output logic [15:0]            TIMEBASE_COUNT_OUT,
	output logic                   TIMEBASE_ENABLE_OUT,
	output ptb_pkg::ptb_mode_e     TIMEBASE_MODE_OUT,
	output logic [1:0]             PRESCALER_SELECT_OUT,
	output logic [3:0]             POSTSCALER_SELECT_OUT,
	output ptb_pkg::ptb_count_t    PERIOD_BUFFER_OUT,
	output ptb_pkg::ptb_count_t    TIMEBASE_PERIOD_OUT,
	output logic                   TIMEBASE_EVENT_OUT
);

	import ptb_pkg::*;

	ptb_scale_if sc ();

	ptb_prescaler u_pre (
		.clk_in   (CLK_IN),
		.reset_in (RESET_IN),
		.sc       (sc.pre)
	);

	ptb_postscaler u_post (
		.clk_in   (CLK_IN),
		.reset_in (RESET_IN),
		.sc       (sc.post)
	);

	// Control group
	logic                enable_r;
	logic                enable_nxt;
	ptb_mode_e           mode_r;
	ptb_mode_e           mode_nxt;
	logic [1:0]          presel_r;
	logic [1:0]          presel_nxt;
	logic [POST_W-1:0]   postsel_r;
	logic [POST_W-1:0]   postsel_nxt;

	// Period group
	ptb_count_t          per_buf_r;
	ptb_count_t          per_buf_nxt;
	ptb_count_t          per_act_r;
	ptb_count_t          per_act_nxt;

	// Counter group
	ptb_count_t          count_r;
	ptb_count_t          count_nxt;
	logic                down_r;
	logic                down_nxt;
	logic                event_r;
	logic                event_nxt;

	// Step decode
	logic                step;
	logic                match;
	logic                updown;
	logic                wrap;
	logic                reach_zero;
	logic                single_done;
	logic                raw_evt;
	logic                direct_evt;

	always_comb begin
		updown      = (mode_r == MODE_UPDOWN) || (mode_r == MODE_UPDOWN_DU);
		match       = (count_r == per_act_r);
		step        = enable_r && sc.tick && (per_act_r != COUNT_ZERO);
		wrap        = step && match && !updown;
		single_done = wrap && (mode_r == MODE_SINGLE);
		reach_zero  = step && updown && down_r && (count_r <= COUNT_ONE);
		sc.clr      = CTRL_WR_IN || COUNT_WR_IN;
		sc.pre_sel  = presel_r;
		sc.post_sel = postsel_r;
		// Postscaled events: free-running wraps and up/down turn at zero
		raw_evt     = (wrap && (mode_r == MODE_FREE))
			|| (reach_zero && (mode_r == MODE_UPDOWN));
		sc.evt_in   = raw_evt;
		// Events that ignore the postscaler
		direct_evt  = single_done
			|| (mode_r == MODE_UPDOWN_DU && (reach_zero || (step && !down_r && match)));
	end

	// Control register: a software write wins over the single-shot clear
	always_comb begin
		enable_nxt  = enable_r;
		mode_nxt    = mode_r;
		presel_nxt  = presel_r;
		postsel_nxt = postsel_r;
		if (CTRL_WR_IN) begin
			enable_nxt  = CTRL_ENABLE_IN;
			mode_nxt    = CTRL_MODE_IN;
			presel_nxt  = CTRL_PRESCALER_IN;
			postsel_nxt = CTRL_POSTSCALER_IN;
		end else if (single_done) begin
			enable_nxt = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			enable_r  <= 1'b0;
			mode_r    <= MODE_RESET;
			presel_r  <= PRESEL_RESET;
			postsel_r <= POSTSEL_RESET;
		end else begin
			enable_r  <= enable_nxt;
			mode_r    <= mode_nxt;
			presel_r  <= presel_nxt;
			postsel_r <= postsel_nxt;
		end
	end

	// Period: buffered write, copied into the active period at the update instants
	always_comb begin
		per_buf_nxt = per_buf_r;
		per_act_nxt = per_act_r;
		if (PERIOD_WR_IN) begin
			per_buf_nxt = PERIOD_WDATA_IN;
		end
		if (per_act_r == COUNT_ZERO) begin
			// A stuck zero period is only replaced with the time base disabled
			if (!enable_r) begin
				per_act_nxt = per_buf_r;
			end
		end else if (!enable_r || wrap || (updown && count_r == COUNT_ZERO)) begin
			per_act_nxt = per_buf_r;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			per_buf_r <= PERIOD_RESET;
			per_act_r <= PERIOD_RESET;
		end else begin
			per_buf_r <= per_buf_nxt;
			per_act_r <= per_act_nxt;
		end
	end

	// Counter and direction
	always_comb begin
		count_nxt = count_r;
		down_nxt  = down_r;
		if (COUNT_WR_IN) begin
			count_nxt = COUNT_WDATA_IN;
		end else if (step) begin
			if (!updown) begin
				down_nxt = 1'b0;
				if (match) begin
					count_nxt = COUNT_ZERO;
				end else begin
					count_nxt = count_r + COUNT_ONE;
				end
			end else if (!down_r) begin
				if (match) begin
					down_nxt  = 1'b1;
					count_nxt = count_r - COUNT_ONE;
				end else begin
					count_nxt = count_r + COUNT_ONE;
				end
			end else if (reach_zero) begin
				down_nxt  = 1'b0;
				count_nxt = COUNT_ZERO;
			end else begin
				count_nxt = count_r - COUNT_ONE;
			end
		end
		event_nxt = sc.evt_out || direct_evt;
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			count_r <= COUNT_RESET;
			down_r  <= 1'b0;
			event_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			down_r  <= down_nxt;
			event_r <= event_nxt;
		end
	end

	// Outputs are direct register copies
	always_comb begin
		TIMEBASE_COUNT_OUT    = {down_r, count_r};
		TIMEBASE_ENABLE_OUT   = enable_r;
		TIMEBASE_MODE_OUT     = mode_r;
		PRESCALER_SELECT_OUT  = presel_r;
		POSTSCALER_SELECT_OUT = postsel_r;
		PERIOD_BUFFER_OUT     = per_buf_r;
		TIMEBASE_PERIOD_OUT   = per_act_r;
		TIMEBASE_EVENT_OUT    = event_r;
	end

endmodule // ptb_timebase

/* bench/ptb_timebase_chk.sv */
module ptb_timebase_chk
	import ptb_pkg::*;
(
	input  wire logic               CLK_IN,
	input  wire logic               RESET_IN,
	input  wire logic               CTRL_WR_IN,
	input  wire ptb_pkg::ptb_mode_e CTRL_MODE_IN,
	input  wire logic [1:0]         CTRL_PRESCALER_IN,
	input  wire logic [3:0]         CTRL_POSTSCALER_IN,
	input  wire logic               COUNT_WR_IN,
	input  wire logic [15:0]        TIMEBASE_COUNT_OUT,
	input  wire logic               TIMEBASE_ENABLE_OUT,
	input  wire ptb_pkg::ptb_mode_e TIMEBASE_MODE_OUT,
	input  wire logic [1:0]         PRESCALER_SELECT_OUT,
	input  wire logic [3:0]         POSTSCALER_SELECT_OUT,
	input  wire ptb_pkg::ptb_count_t TIMEBASE_PERIOD_OUT,
	input  wire logic               TIMEBASE_EVENT_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);

	logic run;
	logic hit;
	// A step is certain this cycle: enabled, 1:1 prescale, no write, nonzero period
	assign run = TIMEBASE_ENABLE_OUT && PRESCALER_SELECT_OUT == 2'h0 && !COUNT_WR_IN && !CTRL_WR_IN
		&& TIMEBASE_PERIOD_OUT != COUNT_ZERO;
	assign hit = TIMEBASE_COUNT_OUT[14:0] == TIMEBASE_PERIOD_OUT;

	a_hold_disabled: assert property (!TIMEBASE_ENABLE_OUT && !COUNT_WR_IN
		|=> $stable(TIMEBASE_COUNT_OUT)) else $error("count moved while disabled");
	a_zero_stop: assert property (TIMEBASE_PERIOD_OUT == COUNT_ZERO && !COUNT_WR_IN
		|=> $stable(TIMEBASE_COUNT_OUT)) else $error("count moved with zero period");
	a_zero_noevt: assert property (TIMEBASE_PERIOD_OUT == COUNT_ZERO [*2]
		|=> !TIMEBASE_EVENT_OUT) else $error("event with zero period");
	a_period_lock: assert property (TIMEBASE_PERIOD_OUT == COUNT_ZERO && TIMEBASE_ENABLE_OUT && !CTRL_WR_IN
		|=> TIMEBASE_PERIOD_OUT == COUNT_ZERO) else $error("zero period reloaded while enabled");
	a_ctrl_readback: assert property (CTRL_WR_IN |=> TIMEBASE_MODE_OUT == $past(CTRL_MODE_IN)
		&& PRESCALER_SELECT_OUT == $past(CTRL_PRESCALER_IN)
		&& POSTSCALER_SELECT_OUT == $past(CTRL_POSTSCALER_IN)) else $error("control readback wrong");
	a_free_wrap: assert property (run && hit && TIMEBASE_MODE_OUT == MODE_FREE
		|=> TIMEBASE_COUNT_OUT[14:0] == COUNT_ZERO) else $error("free mode did not wrap");
	a_single_stop: assert property (run && hit && TIMEBASE_MODE_OUT == MODE_SINGLE
		|=> !TIMEBASE_ENABLE_OUT && TIMEBASE_COUNT_OUT[14:0] == COUNT_ZERO && TIMEBASE_EVENT_OUT)
		else $error("single shot did not stop with event");
	a_updown_turn: assert property (run && hit && !TIMEBASE_COUNT_OUT[15] && TIMEBASE_MODE_OUT[1]
		&& TIMEBASE_PERIOD_OUT > COUNT_ONE |=> TIMEBASE_COUNT_OUT == {1'b1, $past(TIMEBASE_PERIOD_OUT) - COUNT_ONE})
		else $error("up/down did not turn at match");
	a_dbl_match: assert property (run && hit && !TIMEBASE_COUNT_OUT[15] && TIMEBASE_MODE_OUT == MODE_UPDOWN_DU
		|=> TIMEBASE_EVENT_OUT) else $error("no event at double update match");

	c_single: cover property (TIMEBASE_MODE_OUT == MODE_SINGLE && TIMEBASE_EVENT_OUT);
	c_double: cover property (TIMEBASE_MODE_OUT == MODE_UPDOWN_DU && TIMEBASE_EVENT_OUT);
	c_down: cover property (TIMEBASE_COUNT_OUT[15] && TIMEBASE_ENABLE_OUT);
endmodule // ptb_timebase_chk

bind ptb_timebase ptb_timebase_chk u_ptb_timebase_chk (.*);

/* bench/test_ptb_timebase.sv */
module test_ptb_timebase;
	timeunit 1ns;
	timeprecision 100ps;
	import ptb_pkg::*;

	logic        CLK_IN = 1'b0;
	logic        RESET_IN = 1'b1;
	logic        CTRL_WR_IN = 1'b0, CTRL_ENABLE_IN = 1'b0, COUNT_WR_IN = 1'b0, PERIOD_WR_IN = 1'b0;
	ptb_mode_e   CTRL_MODE_IN = MODE_FREE, TIMEBASE_MODE_OUT;
	logic [1:0]  CTRL_PRESCALER_IN = 2'h0, PRESCALER_SELECT_OUT;
	logic [3:0]  CTRL_POSTSCALER_IN = 4'h0, POSTSCALER_SELECT_OUT;
	ptb_count_t  COUNT_WDATA_IN = 15'h0000, PERIOD_WDATA_IN = 15'h0000, PERIOD_BUFFER_OUT, TIMEBASE_PERIOD_OUT;
	logic [15:0] TIMEBASE_COUNT_OUT;
	logic        TIMEBASE_ENABLE_OUT, TIMEBASE_EVENT_OUT;
	int          bad_count = 0, comparisons = 0;
	int          ps[4] = '{0, 2, 0, 1};

	ptb_timebase u_ptb_timebase (.*);

	always #2.5 CLK_IN = ~CLK_IN;

	task tk(input int n);
		repeat (n) @(posedge CLK_IN);
		#1;
	endtask

	task chk(input logic [15:0] e, input logic [15:0] a);
		comparisons++;
		if (a !== e) begin
			bad_count++;
			$display("MISMATCH %0t expected %h got %h", $time, e, a);
		end
	endtask

	task ctrl(input logic en, input ptb_mode_e m, input int pr, input int po);
		@(posedge CLK_IN);
		CTRL_WR_IN <= 1'b1;
		CTRL_ENABLE_IN <= en;
		CTRL_MODE_IN <= m;
		CTRL_PRESCALER_IN <= 2'(pr);
		CTRL_POSTSCALER_IN <= 4'(po);
		@(posedge CLK_IN);
		CTRL_WR_IN <= 1'b0;
	endtask

	task per(input ptb_count_t v);
		@(posedge CLK_IN);
		PERIOD_WR_IN <= 1'b1;
		PERIOD_WDATA_IN <= v;
		@(posedge CLK_IN);
		PERIOD_WR_IN <= 1'b0;
	endtask

	// Fresh start with period 2, then enable in the given mode
	task go(input ptb_mode_e m, input int pr, input int po);
		@(posedge CLK_IN);
		RESET_IN <= 1'b1;
		repeat (2) @(posedge CLK_IN);
		RESET_IN <= 1'b0;
		per(15'h0002);
		ctrl(1'b1, m, pr, po);
	endtask

	// Cycles until the next event pulse, bounded
	task ev(input int e);
		int n;
		n = 0;
		do begin
			tk(1);
			n++;
		end while (TIMEBASE_EVENT_OUT !== 1'b1 && n < 500);
		chk(16'(e), 16'(n));
	endtask

	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge CLK_IN);
		RESET_IN <= 1'b0;
		tk(1);
		chk(16'h0000, TIMEBASE_COUNT_OUT);
		ctrl(1'b1, MODE_FREE, 0, 0);
		per(15'h0005);
		tk(8);
		chk(16'h0000, {1'b0, TIMEBASE_PERIOD_OUT});
		chk(16'h0000, TIMEBASE_COUNT_OUT);
		ctrl(1'b0, MODE_FREE, 0, 0);
		tk(2);
		chk(16'h0005, {1'b0, TIMEBASE_PERIOD_OUT});
		for (int i = 0; i < 4; i++) begin
			go(MODE_FREE, i, ps[i]);
			ev((1 << (2 * i)) * 3 * (ps[i] + 1));
			ev((1 << (2 * i)) * 3 * (ps[i] + 1));
		end
		go(MODE_FREE, 0, 0);
		ctrl(1'b0, MODE_FREE, 0, 0);
		tk(3);
		chk(16'h0002, TIMEBASE_COUNT_OUT);
		go(MODE_SINGLE, 0, 3);
		ev(3);
		chk(16'h0000, {TIMEBASE_COUNT_OUT[14:0], TIMEBASE_ENABLE_OUT});
		go(MODE_UPDOWN_DU, 0, 5);
		ev(3);
		ev(1);
		ev(3);
		go(MODE_UPDOWN, 0, 1);
		tk(3);
		chk(16'h8001, TIMEBASE_COUNT_OUT);
		ev(5);
		ev(8);
		test_done;
	end

	initial begin
		repeat (20000) @(posedge CLK_IN);
		bad_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		test_done;
	end
endmodule // test_ptb_timebase
